/* File: src/atr_consts.vh */
// constants for the acquisition trigger routing and start block
`ifndef ATR_CONSTS_VH
`define ATR_CONSTS_VH

// register byte offsets
`define ATR_OFS_CTRL 8'h00
`define ATR_OFS_ROUTE 8'h04
`define ATR_OFS_EXTEN 8'h08
`define ATR_OFS_PRE 8'h0c
`define ATR_OFS_POST 8'h10
`define ATR_OFS_SDIV 8'h14
`define ATR_OFS_STAT 8'h18
`define ATR_OFS_LIVE 8'h1c

// control register fields
`define ATR_CTRL_PRE_BIT 0
`define ATR_CTRL_OE_BIT 1
`define ATR_CTRL_ARM_BIT 4
`define ATR_CTRL_SWTRIG_BIT 5
`define ATR_CTRL_STOP_BIT 6

// status register fields
`define ATR_STAT_DONE_BIT 3
`define ATR_STAT_CNT_LSB 16

// route register: four bits per timing signal, source code then polarity
`define ATR_ROUTE_STRIDE 4
`define ATR_ROUTE_POL_BIT 3

// reset values
`define ATR_RST_CTRL 2'h0
`define ATR_RST_ROUTE 28'h0000000
`define ATR_RST_EXTEN 7'h00
`define ATR_RST_PRE 16'h0000
`define ATR_RST_POST 16'h0000
`define ATR_RST_SDIV 16'h0000

// timing signal indexes
`define ATR_SIG_START 0
`define ATR_SIG_REF 1
`define ATR_SIG_SCAN 2
`define ATR_SIG_CONV 3
`define ATR_SIG_PAUSE 4
`define ATR_SIG_TBASE 5
`define ATR_SIG_HOLD 6
`define ATR_NSIG 7
`define ATR_NSRC 8

// detection kind per timing signal, 1 = edge, 0 = level
`define ATR_EDGE_MASK 7'h4f

// timing
`define ATR_CLK_NS 10
`define ATR_START_PULSE_MIN_NS 50
`define ATR_START_PULSE_MAX_NS 100

// sequence states
`define ATR_ST_IDLE 3'h0
`define ATR_ST_ARMED 3'h1
`define ATR_ST_PRE 3'h2
`define ATR_ST_WREF 3'h3
`define ATR_ST_POST 3'h4

`endif

/* File: src/atr_sync.v */
// two flip-flop synchroniser for one asynchronous trigger pin
`timescale 1ns/1ns
module atr_sync (
  input wire hclk,
  input wire hresetn,
  input wire din,
  output wire dout
);
  reg meta_r;
  reg sync_r;

  // first stage feeds only the second stage
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;
endmodule

/* File: src/atr_trig_route.v */
// acquisition timing input routing, detection, sequencing and start trigger output
//
// What this block does
// [R1] each of seven timing signals picks front input, bus lines 0-5 or star line
// [R2] every routed input has its own polarity and edge or level detection
// [R3] edge or level detection is fixed by which timing signal is driven
// [R4] external edge pulses must last at least 10 ns; no maximum width
// [R5] external start trigger is edge detected, rising or falling by software
// [R6] selected start edge begins both posttriggered and pretriggered sequences
// [R7] start output repeats the event that really began the sequence
// [R8] start output is an active high pulse of 50 to 100 ns
// [R9] start output driver is disabled after reset until software enables it
// [R10] in pretrigger mode a software command starts unless external source chosen
// [R11] pretrigger keeps scans before and after reference; posttrigger only after
// [R12] reference edges before pretrigger count ends are ignored; then fixed post count
// [R13] start trigger runs the scan counter; software or sample count stops it
// [R14] every routed pin is synchronised before its detector
`timescale 1ns/1ns
`include "atr_consts.vh"
module atr_trig_route #(
  parameter CW = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire front_trigger_input,
  input wire [5:0] trig_bus_in,
  input wire star_trig_in,
  output wire acq_start_trigger_o,
  output wire acq_start_trigger_oe,
  output wire scan_pulse_o,
  output wire post_phase_o,
  output wire acq_active_o
);
  // start pulse length: least time rounded up to whole cycles
  localparam integer PULSE_CYC = (`ATR_START_PULSE_MIN_NS + `ATR_CLK_NS - 1) / `ATR_CLK_NS;
  localparam [3:0] PULSE_LOAD = PULSE_CYC[3:0];
  localparam [6:0] EDGE_MASK = `ATR_EDGE_MASK;

  // software visible state
  reg pre_mode_r;
  reg out_en_r;
  reg [27:0] route_r;
  reg [6:0] ext_en_r;
  reg [CW-1:0] pre_cnt_r;
  reg [CW-1:0] post_cnt_r;
  reg [CW-1:0] scan_div_r;
  reg done_r;

  // bus slave state
  reg wr_pend_r;
  reg rd_pend_r;
  reg [7:0] addr_r;
  reg mapped_r;
  reg [31:0] hrdata_r;

  // sequencer state
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [CW-1:0] cnt_r;
  reg [CW-1:0] cnt_nxt;
  reg [CW-1:0] div_r;
  reg [3:0] pulse_r;
  reg [3:0] pulse_nxt;
  reg start_o_r;
  reg scan_o_r;
  reg post_o_r;
  reg [6:0] lvl_q_r;
  reg fin;

  wire [7:0] pin_raw;
  wire [7:0] pin_s;
  wire [6:0] lvl;
  wire [6:0] evt;
  wire addr_take;
  wire wr_hit;
  wire wr_ctrl;
  wire arm_cmd;
  wire sw_trig;
  wire sw_stop;
  wire done_clr;
  wire running;
  wire tick;
  wire int_scan;
  wire scan_raw;
  wire paused;
  wire scan_ok;
  wire start_evt;
  wire ref_evt;
  wire start_fire;
  reg [31:0] rd_mux;

  // source code 0 front input, 1..6 bus lines 0..5, 7 star line
  assign pin_raw = {star_trig_in, trig_bus_in, front_trigger_input};

  // pins cross into hclk before any routing mux sees them
  genvar g;
  generate
    for (g = 0; g < `ATR_NSRC; g = g + 1) begin : g_pin
      atr_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .din(pin_raw[g]),
        .dout(pin_s[g])
      ); // [R14]
    end
  endgenerate

  // per signal routing, polarity and fixed detection kind
  generate
    for (g = 0; g < `ATR_NSIG; g = g + 1) begin : g_sig
      wire [2:0] sel;
      wire pol;
      assign sel = route_r[`ATR_ROUTE_STRIDE*g+2:`ATR_ROUTE_STRIDE*g]; // [R1]
      assign pol = route_r[`ATR_ROUTE_STRIDE*g+`ATR_ROUTE_POL_BIT]; // [R2]
      // polarity set means falling edge or active low
      assign lvl[g] = pin_s[sel] ^ pol; // [R2]
      // kind comes from the mask, never from software
      assign evt[g] = ext_en_r[g] & (EDGE_MASK[g] ? (lvl[g] & ~lvl_q_r[g]) : lvl[g]); // [R3]
    end
  endgenerate

  // one cycle of history for edge detection; a 10 ns pulse is one clock,
  // so it always spans one sample edge of the synchroniser
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_q_r <= 7'h00;
    end else begin
      lvl_q_r <= lvl; // [R4]
    end
  end

  // ahb-lite address phase capture
  assign addr_take = hsel & htrans[1] & hready;
  assign wr_hit = wr_pend_r & mapped_r;
  assign wr_ctrl = wr_hit & (addr_r == `ATR_OFS_CTRL);
  assign arm_cmd = wr_ctrl & hwdata[`ATR_CTRL_ARM_BIT];
  assign sw_trig = wr_ctrl & hwdata[`ATR_CTRL_SWTRIG_BIT];
  assign sw_stop = wr_ctrl & hwdata[`ATR_CTRL_STOP_BIT];
  assign done_clr = wr_hit & (addr_r == `ATR_OFS_STAT) & hwdata[`ATR_STAT_DONE_BIT];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
      mapped_r <= 1'b0;
    end else begin
      wr_pend_r <= addr_take & hwrite;
      rd_pend_r <= addr_take & ~hwrite;
      if (addr_take) begin
        addr_r <= {haddr[7:2], 2'b00};
        mapped_r <= (haddr[31:5] == 27'h0000000);
      end
    end
  end

  // register writes land in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_mode_r <= 1'b0;
      out_en_r <= 1'b0; // [R9]
      route_r <= `ATR_RST_ROUTE;
      ext_en_r <= `ATR_RST_EXTEN;
      pre_cnt_r <= `ATR_RST_PRE;
      post_cnt_r <= `ATR_RST_POST;
      scan_div_r <= `ATR_RST_SDIV;
    end else if (wr_hit) begin
      case (addr_r)
        `ATR_OFS_CTRL: begin
          pre_mode_r <= hwdata[`ATR_CTRL_PRE_BIT];
          out_en_r <= hwdata[`ATR_CTRL_OE_BIT]; // [R9]
        end
        `ATR_OFS_ROUTE: route_r <= hwdata[27:0]; // [R1]
        `ATR_OFS_EXTEN: ext_en_r <= hwdata[6:0];
        `ATR_OFS_PRE: pre_cnt_r <= hwdata[CW-1:0];
        `ATR_OFS_POST: post_cnt_r <= hwdata[CW-1:0];
        `ATR_OFS_SDIV: scan_div_r <= hwdata[CW-1:0];
        default: begin
        end
      endcase
    end
  end

  // read mux; unmapped or reserved space reads as zero
  always @* begin
    rd_mux = 32'h00000000;
    if (mapped_r) begin
      case (addr_r)
        `ATR_OFS_CTRL: rd_mux = {30'h00000000, out_en_r, pre_mode_r};
        `ATR_OFS_ROUTE: rd_mux = {4'h0, route_r};
        `ATR_OFS_EXTEN: rd_mux = {25'h0000000, ext_en_r};
        `ATR_OFS_PRE: rd_mux[CW-1:0] = pre_cnt_r;
        `ATR_OFS_POST: rd_mux[CW-1:0] = post_cnt_r;
        `ATR_OFS_SDIV: rd_mux[CW-1:0] = scan_div_r;
        `ATR_OFS_STAT: begin
          rd_mux[2:0] = state_r;
          rd_mux[`ATR_STAT_DONE_BIT] = done_r;
          rd_mux[`ATR_STAT_CNT_LSB+CW-1:`ATR_STAT_CNT_LSB] = cnt_r;
        end
        `ATR_OFS_LIVE: rd_mux = {25'h0000000, lvl};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  // one wait state on reads so a write just before is always seen
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (rd_pend_r) begin
      hrdata_r <= rd_mux;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = ~rd_pend_r;
  assign hresp = 1'b0;

  // scan interval counter runs only inside a sequence
  assign running = (state_r == `ATR_ST_PRE) | (state_r == `ATR_ST_WREF) | (state_r == `ATR_ST_POST); // [R13]
  assign tick = ext_en_r[`ATR_SIG_TBASE] ? (lvl[`ATR_SIG_TBASE] & ~lvl_q_r[`ATR_SIG_TBASE]) : 1'b1;
  assign int_scan = running & tick & (div_r == {CW{1'b0}});

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= {CW{1'b0}};
    end else if (!running) begin
      div_r <= scan_div_r; // [R13]
    end else if (tick) begin
      if (div_r == {CW{1'b0}}) begin
        div_r <= scan_div_r;
      end else begin
        div_r <= div_r - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // scans come from the counter or a routed edge; pause level masks them
  assign scan_raw = ext_en_r[`ATR_SIG_SCAN] ? evt[`ATR_SIG_SCAN] : int_scan;
  assign paused = ext_en_r[`ATR_SIG_PAUSE] & lvl[`ATR_SIG_PAUSE];
  assign scan_ok = running & scan_raw & ~paused;

  // start source: routed edge if enabled, else the software command
  assign start_evt = ext_en_r[`ATR_SIG_START] ? evt[`ATR_SIG_START] : sw_trig; // [R5] [R10]
  // without a routed reference the software command stands in for it
  assign ref_evt = ext_en_r[`ATR_SIG_REF] ? evt[`ATR_SIG_REF] : sw_trig;
  assign start_fire = (state_r == `ATR_ST_ARMED) & start_evt & ~sw_stop;

  // sequence next state; stop from software wins everywhere
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    fin = 1'b0;
    if (sw_stop) begin
      state_nxt = `ATR_ST_IDLE; // [R13]
    end else begin
      case (state_r)
        `ATR_ST_IDLE: begin
          if (arm_cmd) begin
            state_nxt = `ATR_ST_ARMED;
          end
        end
        `ATR_ST_ARMED: begin
          if (start_evt) begin
            if (pre_mode_r) begin
              cnt_nxt = pre_cnt_r; // [R6]
              state_nxt = (pre_cnt_r == {CW{1'b0}}) ? `ATR_ST_WREF : `ATR_ST_PRE;
            end else begin
              cnt_nxt = post_cnt_r; // [R6]
              state_nxt = `ATR_ST_POST;
            end
          end
        end
        `ATR_ST_PRE: begin
          // reference edges are not looked at here
          if (scan_ok) begin
            cnt_nxt = cnt_r - {{(CW-1){1'b0}}, 1'b1}; // [R12]
            if (cnt_r == {{(CW-1){1'b0}}, 1'b1}) begin
              state_nxt = `ATR_ST_WREF;
            end
          end
        end
        `ATR_ST_WREF: begin
          if (ref_evt) begin
            cnt_nxt = post_cnt_r; // [R12]
            state_nxt = `ATR_ST_POST;
          end
        end
        `ATR_ST_POST: begin
          if (cnt_r == {CW{1'b0}}) begin
            fin = 1'b1;
            state_nxt = `ATR_ST_IDLE;
          end else if (scan_ok) begin
            cnt_nxt = cnt_r - {{(CW-1){1'b0}}, 1'b1}; // [R12]
            if (cnt_r == {{(CW-1){1'b0}}, 1'b1}) begin
              fin = 1'b1;
              state_nxt = `ATR_ST_IDLE; // [R13]
            end
          end
        end
        default: state_nxt = `ATR_ST_IDLE;
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= `ATR_ST_IDLE;
      cnt_r <= {CW{1'b0}};
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      // completion set wins over a same cycle clear
      if (fin) begin
        done_r <= 1'b1;
      end else if (done_clr) begin
        done_r <= 1'b0;
      end
    end
  end

  // start pulse length counter, loaded by whatever began the sequence
  always @* begin
    pulse_nxt = pulse_r;
    if (start_fire) begin
      pulse_nxt = PULSE_LOAD; // [R7]
    end else if (pulse_r != 4'h0) begin
      pulse_nxt = pulse_r - 4'h1;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_r <= 4'h0;
      start_o_r <= 1'b0;
    end else begin
      pulse_r <= pulse_nxt;
      start_o_r <= (pulse_nxt != 4'h0); // [R8]
    end
  end

  // scan strobe and phase flag; pretrigger scans are kept as well
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scan_o_r <= 1'b0;
      post_o_r <= 1'b0;
    end else begin
      scan_o_r <= scan_ok; // [R11]
      post_o_r <= (state_r == `ATR_ST_POST); // [R11]
    end
  end

  assign acq_start_trigger_o = start_o_r; // [R8]
  assign acq_start_trigger_oe = out_en_r; // [R9]
  assign scan_pulse_o = scan_o_r;
  assign post_phase_o = post_o_r;
  assign acq_active_o = running; // no gap when entering post, no tail after it
endmodule

/* File: bench/atr_properties.sv */
// port checker for the trigger routing block
`timescale 1ns/1ns
module atr_properties #(
  parameter CW = 16
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire acq_start_trigger_o,
  input wire acq_start_trigger_oe,
  input wire scan_pulse_o,
  input wire post_phase_o,
  input wire acq_active_o
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // short aliases keep the properties on one line
  wire take = hsel && htrans[1] && hready;
  wire st = acq_start_trigger_o;
  wire act = acq_active_o;
  pulse_width_a: assert property ($rose(st) |-> st [*5] ##1 !st)
    else $error("start pulse width off");
  oe_by_write_a: assert property ($rose(acq_start_trigger_oe) |-> $past(take && hwrite, 2))
    else $error("output enable rose without a write");
  start_active_a: assert property ($rose(st) |-> act)
    else $error("start pulse without a sequence");
  start_from_idle_a: assert property ($rose(st) |-> !$past(act))
    else $error("start pulse inside a running sequence");
  scan_in_seq_a: assert property (scan_pulse_o |-> $past(act))
    else $error("scan outside a sequence");
  post_in_seq_a: assert property ($rose(post_phase_o) |-> $past(act))
    else $error("post phase outside a sequence");
  // one wait state on reads, none on writes
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_nowait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  cover property ($rose(st));
  cover property ($rose(post_phase_o));
  cover property (scan_pulse_o && post_phase_o);
endmodule
bind atr_trig_route atr_properties #(.CW(CW)) i_props (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .acq_start_trigger_o, .acq_start_trigger_oe, .scan_pulse_o, .post_phase_o, .acq_active_o);

/* File: bench/atr_far_side.sv */
// model of the external trigger sources on the front input and trigger bus
`timescale 1ns/1ns
module atr_far_side (
  input wire hclk,
  output reg front,
  output reg [5:0] tbus,
  output reg star
);
  // sources always drive, idle low until told otherwise
  initial begin
    front = 1'b0;
    tbus = 6'h00;
    star = 1'b0;
  end
  // source code: 0 front, 1 to 6 bus lines, 7 star
  task set_line(input [2:0] src, input v);
    begin
      @(posedge hclk);
      if (src == 3'h0)
        front <= v;
      else if (src == 3'h7)
        star <= v;
      else
        tbus[src - 3'h1] <= v;
    end
  endtask
  // three cycles wide so the synchroniser cannot miss it
  task pulse(input [2:0] src, input v);
    begin
      set_line(src, v);
      repeat (2) @(posedge hclk);
      set_line(src, ~v);
    end
  endtask
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the trigger routing block
`timescale 1ns/1ns
`include "atr_consts.vh"
module testbench;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, front, star, st_o, st_oe, scan, post, act;
  wire [5:0] tbus;
  reg [31:0] q, rq;
  integer num_errors = 0, check_count = 0, nsc = 0, npost = 0, npulse = 0, run = 0, plen = 0;
  always #5 hclk = ~hclk;
  atr_trig_route #(.CW(16)) i_atr_trig_route (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .front_trigger_input(front), .trig_bus_in(tbus),
    .star_trig_in(star), .acq_start_trigger_o(st_o), .acq_start_trigger_oe(st_oe), .scan_pulse_o(scan),
    .post_phase_o(post), .acq_active_o(act));
  atr_far_side i_far_side (.hclk, .front, .tbus, .star);
  // monitor sampled mid-cycle, clear of the edge
  always @(negedge hclk) begin
    if (scan === 1'b1)
      nsc = nsc + 1;
    if (scan === 1'b1 && post === 1'b1)
      npost = npost + 1;
    if (st_o === 1'b1)
      run = run + 1;
    else if (run > 0) begin
      plen = run;
      run = 0;
      npulse = npulse + 1;
    end
  end
  // ready is read mid-cycle, so the edge it acts at is known
  task wt;
    reg ok;
    begin
      ok = 1'b0;
      while (ok !== 1'b1) begin
        @(negedge hclk);
        ok = hreadyout;
        rq = hrdata;
        @(posedge hclk);
      end
    end
  endtask
  task xfer(input w, input [31:0] a, d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wt;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wt;
      q = rq;
    end
  endtask
  task chk(input [31:0] e, g, input [63:0] n);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("wrong value %0s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task rdc(input [31:0] a, e, input [63:0] n);
    begin
      xfer(1'b0, a, 32'h0);
      chk(e, q, n);
    end
  endtask
  // bounded poll of the state field
  task wait_st(input [2:0] s);
    integer k;
    begin
      k = 0;
      q = 32'hffffffff;
      while (q[2:0] !== s && k < 80) begin
        xfer(1'b0, `ATR_OFS_STAT, 32'h0);
        k = k + 1;
      end
      chk(s, q[2:0], "state");
    end
  endtask
  task give_verdict;
    begin
      if (num_errors == 0 && check_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial begin
    #300000;
    num_errors = num_errors + 1;
    give_verdict;
  end
  initial begin : main
    integer a;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, the last address is unmapped
    for (a = 0; a <= 32; a = a + 4)
      rdc(a, 32'h0, "reset");
    chk(32'h0, st_oe, "oe");
    chk(32'h0, hresp, "hresp");
    chk(32'h0, act, "active");
    // field widths and an ignored unmapped write
    xfer(1'b1, `ATR_OFS_ROUTE, 32'hffffffff);
    rdc(`ATR_OFS_ROUTE, 32'h0fffffff, "route");
    xfer(1'b1, `ATR_OFS_EXTEN, 32'hffffffff);
    rdc(`ATR_OFS_EXTEN, 32'h7f, "exten");
    xfer(1'b1, 32'h20, 32'hffffffff);
    rdc(32'h20, 32'h0, "unmapped");
    xfer(1'b1, `ATR_OFS_CTRL, 32'h3);
    rdc(`ATR_OFS_CTRL, 32'h3, "ctrl");
    chk(32'h1, st_oe, "oe");
    xfer(1'b1, `ATR_OFS_ROUTE, 32'h0);
    xfer(1'b1, `ATR_OFS_EXTEN, 32'h0);
    // posttriggered software start
    xfer(1'b1, `ATR_OFS_SDIV, 32'h1);
    xfer(1'b1, `ATR_OFS_POST, 32'h3);
    xfer(1'b1, `ATR_OFS_CTRL, 32'h12);
    wait_st(3'h1);
    nsc = 0;
    npost = 0;
    xfer(1'b1, `ATR_OFS_CTRL, 32'h22);
    wait_st(3'h0);
    chk(32'h1, q[3], "done");
    chk(32'h3, npost, "postscan");
    chk(32'h3, nsc, "scans");
    chk(32'h5, plen, "pulse");
    chk(32'h1, npulse, "npulse");
    // pretriggered, external falling start, early reference ignored
    i_far_side.set_line(3'h0, 1'b1);
    i_far_side.set_line(3'h7, 1'b1);
    xfer(1'b1, `ATR_OFS_ROUTE, 32'h00070028);
    xfer(1'b1, `ATR_OFS_EXTEN, 32'h3);
    xfer(1'b1, `ATR_OFS_PRE, 32'h4);
    xfer(1'b1, `ATR_OFS_POST, 32'h2);
    xfer(1'b1, `ATR_OFS_SDIV, 32'h9);
    rdc(`ATR_OFS_LIVE, 32'h7c, "live");
    i_far_side.set_line(3'h7, 1'b0);
    xfer(1'b1, `ATR_OFS_CTRL, 32'h13);
    xfer(1'b1, `ATR_OFS_CTRL, 32'h23);
    wait_st(3'h1);
    nsc = 0;
    npost = 0;
    i_far_side.pulse(3'h0, 1'b0);
    i_far_side.pulse(3'h2, 1'b1);
    wait_st(3'h2);
    chk(32'h0, post, "post");
    chk(32'h2, npulse, "npulse");
    wait_st(3'h3);
    i_far_side.pulse(3'h2, 1'b1);
    wait_st(3'h0);
    chk(32'h2, npost, "postscan");
    chk(32'h1, nsc >= 6, "prescan");
    // software stop in mid sequence; star line gates scans meanwhile
    xfer(1'b1, `ATR_OFS_EXTEN, 32'h10);
    xfer(1'b1, `ATR_OFS_POST, 32'h100);
    xfer(1'b1, `ATR_OFS_CTRL, 32'h12);
    xfer(1'b1, `ATR_OFS_CTRL, 32'h22);
    wait_st(3'h4);
    chk(32'h1, act, "active");
    i_far_side.set_line(3'h7, 1'b1);
    // let the star level cross the synchroniser and scans in flight drain before counting
    repeat (4) @(posedge hclk);
    nsc = 0;
    repeat (30) @(posedge hclk);
    chk(32'h0, nsc, "paused");
    i_far_side.set_line(3'h7, 1'b0);
    repeat (30) @(posedge hclk);
    chk(32'h1, nsc >= 2, "unpaused");
    xfer(1'b1, `ATR_OFS_CTRL, 32'h42);
    wait_st(3'h0);
    chk(32'h0, act, "active");
    give_verdict;
  end
endmodule
